// ---- include/rvlc_dec_if.sv ----
// rvlc_dec_if: carries register field values to the voltage decoder and the decoded results back
// assumes: one register end and one decoder end, both combinational on these signals
`timescale 1ns/1ps
interface rvlc_dec_if;
    logic [7:0]  ch0_alt_target_code;
    logic [6:0]  regulator_target_code;
    logic        regulator_range_offset;
    logic [2:0]  regulator_slot_select;
    logic [12:0] ch0_alt_mv;
    logic [12:0] regulator_mv;
    logic [1:0]  slot;
    logic        slot_mode;
    logic        force_on;
    logic        force_off;

    modport regs (
        output ch0_alt_target_code,
        output regulator_target_code,
        output regulator_range_offset,
        output regulator_slot_select,
        input  ch0_alt_mv,
        input  regulator_mv,
        input  slot,
        input  slot_mode,
        input  force_on,
        input  force_off
    );

    modport dec (
        input  ch0_alt_target_code,
        input  regulator_target_code,
        input  regulator_range_offset,
        input  regulator_slot_select,
        output ch0_alt_mv,
        output regulator_mv,
        output slot,
        output slot_mode,
        output force_on,
        output force_off
    );
endinterface

// ---- include/rvlc_pkg.sv ----
// rvlc_pkg: constants, state type and voltage decode functions for the rail voltage / regulator config registers
// assumes: used by rvlc_regs and rvlc_volt_decode; referenced only as rvlc_pkg::name, never imported
package rvlc_pkg;

    // register offsets on the internal register port
    localparam logic [7:0] OFS_CH0_ALT_VOLTAGE_CFG = 8'h2F;
    localparam logic [7:0] OFS_LDO_VOLTAGE_CFG     = 8'h38;
    localparam logic [7:0] OFS_LDO_CONTROL_CFG     = 8'h39;

    // reset values; the regulator ones stand in for factory-programmed defaults
    localparam logic [7:0] RST_CH0_ALT_VOLTAGE_CFG = 8'h14;
    localparam logic [7:0] RST_LDO_VOLTAGE_CFG     = 8'h00;
    localparam logic [7:0] RST_LDO_CONTROL_CFG     = 8'h00;
    localparam logic [7:0] RST_READ_DATA           = 8'h00;

    // field positions
    localparam int RANGE_OFFSET_BIT  = 7;
    localparam int TARGET_CODE_MSB   = 6;
    localparam int RSVD_MSB          = 7;
    localparam int RSVD_LSB          = 5;
    localparam int SWITCH_SELECT_BIT = 4;
    localparam int DISCHARGE_EN_BIT  = 3;
    localparam int SLOT_SELECT_MSB   = 2;

    // slot-select encodings: 0..3 sequence slot, 10x force off, 11x force on
    localparam logic [2:0] SLOT_FORCE_OFF = 3'h4;
    localparam logic [2:0] SLOT_FORCE_ON  = 3'h6;

    // voltage transfer constants, in millivolts
    localparam logic [12:0] MV_BASE      = 13'h01F4; // 500 mV at code zero
    localparam logic [12:0] MV_STEP      = 13'h0019; // 25 mV per code
    localparam logic [12:0] MV_OFFSET    = 13'h052D; // 1325 mV range offset
    localparam logic [12:0] MV_ALT_MAX   = 13'h157C; // 5500 mV ceiling
    localparam logic [7:0]  ALT_SAT_CODE = 8'hC8;    // first saturating code

    localparam int MV_W = 13;

    // channel-0 alternate target: linear, saturating at the top codes
    function automatic logic [12:0] alt_mv(input logic [7:0] code);
        logic [12:0] lin;
        lin = MV_BASE + 13'(MV_STEP * 13'(code));
        if (code >= ALT_SAT_CODE) begin
            alt_mv = MV_ALT_MAX;
        end else begin
            alt_mv = lin;
        end
    endfunction

    // regulator target: seven-bit linear code plus optional fixed offset
    function automatic logic [12:0] ldo_mv(input logic [6:0] code, input logic ofs);
        ldo_mv = MV_BASE + 13'(MV_STEP * 13'(code)) + (ofs ? MV_OFFSET : 13'h0000);
    endfunction

    // whole state of the register block, one packed word
    typedef struct packed {
        logic [7:0]  ch0_alt_voltage_cfg;
        logic [7:0]  ldo_voltage_cfg;
        logic [7:0]  ldo_control_cfg;
        logic [7:0]  read_data;
        logic        read_valid;
        logic [12:0] ch0_alt_mv;
        logic [12:0] ldo_mv;
        logic        switch_mode;
        logic        discharge_on;
        logic [1:0]  slot;
        logic        slot_mode;
        logic        force_on;
        logic        force_off;
    } rvlc_state_t;

endpackage

// ---- sim/rvlc_regs_checker.sv ----
// rvlc_regs_checker: concurrent checks on the register port and the decoded outputs
// assumes: bound to rvlc_regs, sees only its ports; one clock domain, async active-low reset
`timescale 1ns/1ps
module rvlc_regs_checker #(
    parameter logic [7:0] LDO_VOLTAGE_RST = 8'h00,
    parameter logic [7:0] LDO_CONTROL_RST = 8'h00
) (
    input wire logic        core_clk_i,
    input wire logic        rst_b_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        reg_rvalid_o,
    input wire logic        ldo_enabled_i,
    input wire logic [12:0] ch0_alt_target_mv_o,
    input wire logic [12:0] regulator_target_mv_o,
    input wire logic        regulator_switch_select_o,
    input wire logic        discharge_resistor_on_o,
    input wire logic [1:0]  regulator_slot_o,
    input wire logic        regulator_slot_mode_o,
    input wire logic        regulator_force_on_o,
    input wire logic        regulator_force_off_o
);
    // shadow of the discharge enable bit, the stored register is not visible at the ports
    logic ade_r;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ade_r <= LDO_CONTROL_RST[3];
        end else if (reg_wr_i && reg_addr_i == 8'h39) begin
            ade_r <= reg_wdata_i[3];
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence seq_wr(logic [7:0] a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    // discharge output is registered, so only judge it once its causes sat still two cycles
    sequence seq_quiet;
        $stable(ade_r) && $stable(ldo_enabled_i) ##1 $stable(ade_r) && $stable(ldo_enabled_i);
    endsequence

    chk_alt_linear: assert property (seq_wr(8'h2F) ##0 reg_wdata_i < 8'hC8 |=>
        ch0_alt_target_mv_o == 13'h01F4 + 13'h0019 * {5'h00, $past(reg_wdata_i)}) else $error("alt target decode");
    chk_alt_saturate: assert property (seq_wr(8'h2F) ##0 reg_wdata_i >= 8'hC8 |=>
        ch0_alt_target_mv_o == 13'h157C) else $error("alt target not saturated");
    chk_ldo_plain: assert property (seq_wr(8'h38) ##0 !reg_wdata_i[7] |=>
        regulator_target_mv_o == 13'h01F4 + 13'h0019 * {6'h00, $past(reg_wdata_i[6:0])}) else $error("ldo decode");
    chk_ldo_offset: assert property (seq_wr(8'h38) ##0 reg_wdata_i[7] |=>
        regulator_target_mv_o == 13'h0721 + 13'h0019 * {6'h00, $past(reg_wdata_i[6:0])}) else $error("ldo offset");
    chk_switch_mode: assert property (seq_wr(8'h39) |=>
        regulator_switch_select_o == $past(reg_wdata_i[4])) else $error("switch select");
    chk_slot_decode: assert property (seq_wr(8'h39) |=> {regulator_slot_mode_o, regulator_force_off_o,
        regulator_force_on_o, regulator_slot_o} == ($past(reg_wdata_i[2]) ? {1'b0, !$past(reg_wdata_i[1]),
        $past(reg_wdata_i[1]), 2'b00} : {3'b100, $past(reg_wdata_i[1:0])})) else $error("slot decode");
    chk_discharge_on: assert property (seq_quiet ##0 (ade_r && !ldo_enabled_i) |->
        discharge_resistor_on_o) else $error("discharge not connected");
    chk_discharge_off: assert property (seq_quiet ##0 (!ade_r || ldo_enabled_i) |->
        !discharge_resistor_on_o) else $error("discharge wrongly connected");
    chk_read_pulse: assert property (reg_rd_i ##1 !reg_rd_i |-> reg_rvalid_o ##1 !reg_rvalid_o)
        else $error("read valid pulse");
    chk_cfg_hold: assert property (!reg_wr_i || !(reg_addr_i inside {8'h2F, 8'h38, 8'h39}) |=>
        $stable(ch0_alt_target_mv_o) && $stable(regulator_target_mv_o) && $stable(regulator_slot_o))
        else $error("config changed without write");
endmodule

bind rvlc_regs rvlc_regs_checker #(.LDO_VOLTAGE_RST(LDO_VOLTAGE_RST), .LDO_CONTROL_RST(LDO_CONTROL_RST)) u_chk (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .ldo_enabled_i(ldo_enabled_i), .ch0_alt_target_mv_o(ch0_alt_target_mv_o),
    .regulator_target_mv_o(regulator_target_mv_o), .regulator_switch_select_o(regulator_switch_select_o),
    .discharge_resistor_on_o(discharge_resistor_on_o), .regulator_slot_o(regulator_slot_o),
    .regulator_slot_mode_o(regulator_slot_mode_o), .regulator_force_on_o(regulator_force_on_o),
    .regulator_force_off_o(regulator_force_off_o));

// ---- sim/tb_rvlc_regs.sv ----
// tb_rvlc_regs: self-checking bench for the channel-0 alternate target and regulator config registers
// assumes: rvlc_regs with default reset parameters; the checker arrives by bind
`timescale 1ns/1ps
module tb_rvlc_regs;
    logic        core_clk_i;
    logic        rst_b_i;
    logic [7:0]  reg_addr_i;
    logic        reg_wr_i;
    logic [7:0]  reg_wdata_i;
    logic        reg_rd_i;
    logic [7:0]  reg_rdata_o;
    logic        reg_rvalid_o;
    logic        ldo_enabled_i;
    logic [12:0] ch0_alt_target_mv_o;
    logic [12:0] regulator_target_mv_o;
    logic        regulator_switch_select_o;
    logic        discharge_resistor_on_o;
    logic [1:0]  regulator_slot_o;
    logic        regulator_slot_mode_o;
    logic        regulator_force_on_o;
    logic        regulator_force_off_o;
    int          n_errors;
    int          samples_checked;
    logic [7:0]  v;
    logic [7:0]  corners [8] = '{8'h00, 8'hC7, 8'hC8, 8'hFF, 8'h00, 8'h7F, 8'h80, 8'hFF};

    rvlc_regs uut (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .ldo_enabled_i(ldo_enabled_i), .ch0_alt_target_mv_o(ch0_alt_target_mv_o),
        .regulator_target_mv_o(regulator_target_mv_o), .regulator_switch_select_o(regulator_switch_select_o),
        .discharge_resistor_on_o(discharge_resistor_on_o), .regulator_slot_o(regulator_slot_o),
        .regulator_slot_mode_o(regulator_slot_mode_o), .regulator_force_on_o(regulator_force_on_o),
        .regulator_force_off_o(regulator_force_off_o));

    // expectations, worked out independently of the package functions
    function automatic logic [15:0] exp_alt(input logic [7:0] c);
        return (c >= 8'hC8) ? 16'h157C : 16'h01F4 + 16'h0019 * {8'h00, c};
    endfunction
    function automatic logic [15:0] exp_ldo(input logic [7:0] c);
        return 16'h01F4 + 16'h0019 * {9'h000, c[6:0]} + (c[7] ? 16'h052D : 16'h0000);
    endfunction
    function automatic logic [15:0] exp_slot(input logic [2:0] c);
        return {11'h000, c[2] ? {1'b0, ~c[1], c[1], 2'b00} : {3'b100, c[1:0]}};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // strobes rise after one edge and fall after the next, so each request is taken exactly once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        chk({7'h00, reg_rvalid_o, reg_rdata_o}, {8'h01, exp});
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    // watchdog: fires after 10000 cycles, well above what the sequence needs
    initial begin
        #100000;
        n_errors++;
        stop_test();
    end

    initial begin
        rst_b_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_wdata_i = 8'h00;
        reg_rd_i = 1'b0;
        ldo_enabled_i = 1'b1;
        n_errors = 0;
        samples_checked = 0;
        void'($urandom(14));
        repeat (10) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        #1;
        chk({3'h0, ch0_alt_target_mv_o}, 16'h03E8);
        rd(8'h2F, 8'h14);
        rd(8'h38, 8'h00);
        rd(8'h39, 8'h00);
        // corner codes first, then random ones
        for (int i = 0; i < 24; i++) begin
            v = (i < 4) ? corners[i] : 8'($urandom);
            wr(8'h2F, v);
            chk({3'h0, ch0_alt_target_mv_o}, exp_alt(v));
            rd(8'h2F, v);
            v = (i < 4) ? corners[i + 4] : 8'($urandom);
            wr(8'h38, v);
            chk({3'h0, regulator_target_mv_o}, exp_ldo(v));
            rd(8'h38, v);
        end
        // every slot code with both modes; reserved bits kept at zero
        for (int i = 0; i < 16; i++) begin
            v = {3'h0, i[3], 1'($urandom), i[2:0]};
            wr(8'h39, v);
            chk({15'h0000, regulator_switch_select_o}, {15'h0000, v[4]});
            chk({11'h000, regulator_slot_mode_o, regulator_force_off_o, regulator_force_on_o,
                 regulator_slot_o}, exp_slot(v[2:0]));
            rd(8'h39, v);
        end
        // discharge enable against regulator on and off
        for (int j = 0; j < 4; j++) begin
            wr(8'h39, {4'h0, j[1], 3'h6});
            // the regulator state moves on a clock edge like every other input
            @(posedge core_clk_i);
            ldo_enabled_i <= j[0];
            repeat (2) @(posedge core_clk_i);
            #1;
            chk({15'h0000, discharge_resistor_on_o}, {15'h0000, j[1] & ~j[0]});
        end
        // an unmapped write must leave the mapped registers alone
        wr(8'h2F, 8'h28);
        wr(8'h30, 8'hA5);
        rd(8'h30, 8'h00);
        rd(8'h2F, 8'h28);
        chk({3'h0, ch0_alt_target_mv_o}, exp_alt(8'h28));
        // a reset in mid-run must bring back every reset value over the written ones
        @(posedge core_clk_i);
        rst_b_i <= 1'b0;
        @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        #1;
        chk({3'h0, ch0_alt_target_mv_o}, 16'h03E8);
        chk({3'h0, regulator_target_mv_o}, 16'h01F4);
        chk({11'h000, regulator_slot_mode_o, regulator_force_off_o, regulator_force_on_o,
             regulator_slot_o}, exp_slot(3'h0));
        rd(8'h2F, 8'h14);
        rd(8'h39, 8'h00);
        stop_test();
    end
endmodule

// ---- src/rvlc_regs.sv ----
// rvlc_regs: configuration registers for the channel-0 alternate target and the linear regulator
// assumes: a synchronous internal register port in front (the serial host port is outside this block);
// assumes: the power sequencer reports the regulator's on/off state on ldo_enabled_i
//
// Summary of operation
// - the channel-0 alternate target code maps to 0.5 V plus 25 mV per code step.
// - alternate target codes 0xC8 to 0xFF all give the 5.500 V ceiling instead of wrapping.
// - the seven-bit regulator target code gives 0.5 V plus 25 mV per step, up to 3.675 V.
// - bit 7 of the regulator voltage register adds a fixed 1.325 V when set and nothing when clear.
// - with that offset bit set the regulator range runs from 1.825 V to 5 V.
// - the mode bit at position 4 selects linear regulation at 0 and plain load switch at 1.
// - with discharge enable at 1 and the regulator off, the internal discharge resistor is connected.
// - with discharge enable at 0 the discharge path stays off, so the output only decays passively.
// - the slot select field picks slot 0 to 3 for codes 0 to 3, forces off for 4 or 5, on for 6 or 7.
`timescale 1ns/1ps
module rvlc_regs #(
    parameter logic [7:0] LDO_VOLTAGE_RST = rvlc_pkg::RST_LDO_VOLTAGE_CFG,
    parameter logic [7:0] LDO_CONTROL_RST = rvlc_pkg::RST_LDO_CONTROL_CFG
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    // internal register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    output logic             reg_rvalid_o,
    // regulator state from the sequencer
    input  wire logic        ldo_enabled_i,
    // decoded configuration towards the analog and sequencer
    output logic      [12:0] ch0_alt_target_mv_o,
    output logic      [12:0] regulator_target_mv_o,
    output logic             regulator_switch_select_o,
    output logic             discharge_resistor_on_o,
    output logic      [1:0]  regulator_slot_o,
    output logic             regulator_slot_mode_o,
    output logic             regulator_force_on_o,
    output logic             regulator_force_off_o
);

    // reset image: raw fields plus their decodes, with discharge_on loaded as 0, so the other outputs
    // agree with the registers from the very first cycle without waiting for a write
    localparam rvlc_pkg::rvlc_state_t RESET_STATE = '{
        ch0_alt_voltage_cfg: rvlc_pkg::RST_CH0_ALT_VOLTAGE_CFG,
        ldo_voltage_cfg:     LDO_VOLTAGE_RST,
        ldo_control_cfg:     LDO_CONTROL_RST,
        read_data:           rvlc_pkg::RST_READ_DATA,
        read_valid:          1'b0,
        ch0_alt_mv:          rvlc_pkg::alt_mv(rvlc_pkg::RST_CH0_ALT_VOLTAGE_CFG),
        ldo_mv:              rvlc_pkg::ldo_mv(LDO_VOLTAGE_RST[rvlc_pkg::TARGET_CODE_MSB:0],
                                              LDO_VOLTAGE_RST[rvlc_pkg::RANGE_OFFSET_BIT]),
        switch_mode:         LDO_CONTROL_RST[rvlc_pkg::SWITCH_SELECT_BIT],
        discharge_on:        1'b0,
        slot:                (LDO_CONTROL_RST[2]) ? 2'h0 : LDO_CONTROL_RST[1:0],
        slot_mode:           ~LDO_CONTROL_RST[2],
        force_on:            LDO_CONTROL_RST[2] & LDO_CONTROL_RST[1],
        force_off:           LDO_CONTROL_RST[2] & ~LDO_CONTROL_RST[1]
    };

    rvlc_pkg::rvlc_state_t state_r;
    rvlc_pkg::rvlc_state_t state_nxt;

    rvlc_dec_if dec_if ();

    // the decoder sees next-state fields, so decoded outputs move on the
    // same edge as the register that a write changes
    rvlc_volt_decode u_decode (
        .dec (dec_if.dec)
    );

    assign dec_if.ch0_alt_target_code    = state_nxt.ch0_alt_voltage_cfg;
    assign dec_if.regulator_target_code  = state_nxt.ldo_voltage_cfg[rvlc_pkg::TARGET_CODE_MSB:0];
    assign dec_if.regulator_range_offset = state_nxt.ldo_voltage_cfg[rvlc_pkg::RANGE_OFFSET_BIT];
    assign dec_if.regulator_slot_select  = state_nxt.ldo_control_cfg[rvlc_pkg::SLOT_SELECT_MSB:0];

    // read mux; unmapped addresses read as zero
    function automatic logic [7:0] read_mux(input logic [7:0] addr, input rvlc_pkg::rvlc_state_t s);
        if (addr == rvlc_pkg::OFS_CH0_ALT_VOLTAGE_CFG) begin
            read_mux = s.ch0_alt_voltage_cfg;
        end else if (addr == rvlc_pkg::OFS_LDO_VOLTAGE_CFG) begin
            read_mux = s.ldo_voltage_cfg;
        end else if (addr == rvlc_pkg::OFS_LDO_CONTROL_CFG) begin
            read_mux = s.ldo_control_cfg;
        end else begin
            read_mux = 8'h00;
        end
    endfunction

    // next state: register writes, read capture, registered decodes
    always_comb begin
        state_nxt = state_r;

        // writes store all eight bits; reserved control bits are kept as
        // written because software is expected to put zero there and ignore them
        if (reg_wr_i) begin
            if (reg_addr_i == rvlc_pkg::OFS_CH0_ALT_VOLTAGE_CFG) begin
                state_nxt.ch0_alt_voltage_cfg = reg_wdata_i;
            end else if (reg_addr_i == rvlc_pkg::OFS_LDO_VOLTAGE_CFG) begin
                state_nxt.ldo_voltage_cfg = reg_wdata_i;
            end else if (reg_addr_i == rvlc_pkg::OFS_LDO_CONTROL_CFG) begin
                state_nxt.ldo_control_cfg = reg_wdata_i;
            end
        end

        // a read returns the value held before any write in the same cycle
        state_nxt.read_valid = reg_rd_i;
        if (reg_rd_i) begin
            state_nxt.read_data = read_mux(reg_addr_i, state_r);
        end

        // voltage targets from the shared transfer functions
        state_nxt.ch0_alt_mv = dec_if.ch0_alt_mv;
        state_nxt.ldo_mv     = dec_if.regulator_mv;

        // mode bit passes straight through: 0 regulates, 1 acts as a load switch
        state_nxt.switch_mode = state_nxt.ldo_control_cfg[rvlc_pkg::SWITCH_SELECT_BIT];

        // discharge resistor only while disabled and only when enabled by software;
        // a disabled enable leaves the path off so the rail decays passively
        state_nxt.discharge_on = state_nxt.ldo_control_cfg[rvlc_pkg::DISCHARGE_EN_BIT] & ~ldo_enabled_i;

        // slot decode
        state_nxt.slot      = dec_if.slot;
        state_nxt.slot_mode = dec_if.slot_mode;
        state_nxt.force_on  = dec_if.force_on;
        state_nxt.force_off = dec_if.force_off;
    end

    // single state register; reset loads the constant image only
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= RESET_STATE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // all outputs come straight from the state register
    assign reg_rdata_o               = state_r.read_data;
    assign reg_rvalid_o              = state_r.read_valid;
    assign ch0_alt_target_mv_o       = state_r.ch0_alt_mv;
    assign regulator_target_mv_o     = state_r.ldo_mv;
    assign regulator_switch_select_o = state_r.switch_mode;
    assign discharge_resistor_on_o   = state_r.discharge_on;
    assign regulator_slot_o          = state_r.slot;
    assign regulator_slot_mode_o     = state_r.slot_mode;
    assign regulator_force_on_o      = state_r.force_on;
    assign regulator_force_off_o     = state_r.force_off;

endmodule

// ---- src/rvlc_volt_decode.sv ----
// rvlc_volt_decode: pure combinational decode of target codes to millivolts and of the slot-select field
// assumes: fed with next-state field values so that results can be registered on the same edge as the fields
`timescale 1ns/1ps
module rvlc_volt_decode (
    rvlc_dec_if.dec dec
);

    // voltage transfer functions shared with the reset values in the package
    assign dec.ch0_alt_mv   = rvlc_pkg::alt_mv(dec.ch0_alt_target_code);
    assign dec.regulator_mv = rvlc_pkg::ldo_mv(dec.regulator_target_code, dec.regulator_range_offset);

    // slot select: low codes pick a sequence slot, upper half forces the regulator
    always_comb begin
        dec.slot      = dec.regulator_slot_select[1:0];
        dec.slot_mode = 1'b0;
        dec.force_on  = 1'b0;
        dec.force_off = 1'b0;
        if ((dec.regulator_slot_select & rvlc_pkg::SLOT_FORCE_ON) == rvlc_pkg::SLOT_FORCE_ON) begin
            dec.force_on = 1'b1;
            dec.slot     = 2'h0;
        end else if ((dec.regulator_slot_select & rvlc_pkg::SLOT_FORCE_OFF) == rvlc_pkg::SLOT_FORCE_OFF) begin
            dec.force_off = 1'b1;
            dec.slot      = 2'h0;
        end else begin
            dec.slot_mode = 1'b1;
        end
    end

endmodule
